// ---- include/pin_routing_pkg.sv ----
// register map, field positions and reset values for the serial pin routing block
package pin_routing_pkg;

  // ------------------------------------------------------------
  // register byte addresses (one register per byte offset, not word aligned)
  // ------------------------------------------------------------
  localparam logic [15:0] port0_output_data_addr       = 16'hF204;
  localparam logic [15:0] port0_drive_ctrl_low_addr    = 16'hF206;
  localparam logic [15:0] port0_drive_ctrl_high_addr   = 16'hF207;
  localparam logic [15:0] port5_output_data_addr       = 16'hF228;
  localparam logic [15:0] port5_direction_addr         = 16'hF229;
  localparam logic [15:0] port5_drive_ctrl_low_addr    = 16'hF22A;
  localparam logic [15:0] port5_drive_ctrl_high_addr   = 16'hF22B;
  localparam logic [15:0] port5_function_sel_low_addr  = 16'hF22C;
  localparam logic [15:0] port5_function_sel_high_addr = 16'hF22D;
  localparam logic [15:0] chan1_mode_reg0_addr         = 16'hF230;
  localparam logic [15:0] pin_status_addr              = 16'hF234;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int tx_bit          = 3;
  localparam int rx_alt_bit      = 2;
  localparam int rx_input_bit    = 3;
  localparam int rx_sel_bit      = 4;
  localparam int port0_width     = 4;
  localparam int port5_width     = 4;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] data_reset      = 8'h00;
  localparam logic [7:0] dir_reset       = 8'h00;
  localparam logic [7:0] drive_reset     = 8'h00;
  localparam logic [7:0] func_reset      = 8'h00;
  localparam logic [7:0] mode_reset      = 8'h00;

  // secondary function code: high select 0, low select 1
  localparam logic [1:0] func_secondary  = 2'h1;
  // push-pull output drive code: both drive bits 1
  localparam logic [1:0] drive_push_pull = 2'h3;

endpackage

// ---- tb/serial_peer.sv ----
// far-side serial device model for the pin routing bench
`timescale 1ns/1ps
module serial_peer (
  input  wire logic tx_o_i,
  input  wire logic tx_oe_i,
  input  wire logic alt_o_i,
  input  wire logic alt_oe_i,
  input  wire logic alt_level_i,
  input  wire logic in_level_i,
  output logic      tx_wire_o,
  output logic      alt_wire_o,
  output logic      in_wire_o
);
  // ----------------------------------------
  // wire resolution
  // ----------------------------------------
  // pull-up on the tx line, so a released pin reads high, never the last value
  assign tx_wire_o  = tx_oe_i ? tx_o_i : 1'b1;
  // peer drives the alt line only while the device has let go of it
  assign alt_wire_o = alt_oe_i ? alt_o_i : alt_level_i;
  // input-only line, always driven by the peer
  assign in_wire_o  = in_level_i;
endmodule // serial_peer

// ---- tb/uart1_pin_routing_tb.sv ----
// self-checking bench for the serial pin routing block
`timescale 1ns/1ps
module uart1_pin_routing_tb
  import pin_routing_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [31:0] dat = 32'h00000000;
  logic        tx_line = 1'b1;
  logic        alt_lvl = 1'b1;
  logic        in_lvl = 1'b1;
  logic        ce = 1'b1;
  logic [3:0]  sel = 4'h1;
  logic [31:0] dat_o;
  logic        ack_o, rx_o, tx_o, tx_oe, alt_o, alt_oe, tx_w, alt_w, in_w;
  logic [1:0]  alt_pm, in_pm;
  int          error_cnt = 0;
  int          n_compared = 0;
  localparam logic [15:0] map [10] = '{port0_output_data_addr, port0_drive_ctrl_low_addr,
    port0_drive_ctrl_high_addr, port5_output_data_addr, port5_direction_addr,
    port5_drive_ctrl_low_addr, port5_drive_ctrl_high_addr, port5_function_sel_low_addr,
    port5_function_sel_high_addr, chan1_mode_reg0_addr};
  localparam logic [7:0] rst_val [10] = '{data_reset, drive_reset, drive_reset, data_reset,
    dir_reset, drive_reset, drive_reset, func_reset, func_reset, mode_reset};

  // 50 ns period clock
  always #25 clk_i = ~clk_i;

  uart1_pin_routing dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .chan1_transmit_line_i(tx_line), .chan1_receive_line_o(rx_o),
    .serial_tx_port_pin_i(tx_w), .serial_tx_port_pin_o(tx_o), .serial_tx_port_pin_oe_o(tx_oe),
    .serial_rx_alt_port_pin_i(alt_w), .serial_rx_alt_port_pin_o(alt_o),
    .serial_rx_alt_port_pin_oe_o(alt_oe), .serial_rx_input_only_pin_i(in_w),
    .rx_alt_pull_mode_o(alt_pm), .rx_input_pull_mode_o(in_pm));

  serial_peer peer (.tx_o_i(tx_o), .tx_oe_i(tx_oe), .alt_o_i(alt_o), .alt_oe_i(alt_oe),
    .alt_level_i(alt_lvl), .in_level_i(in_lvl), .tx_wire_o(tx_w), .alt_wire_o(alt_w),
    .in_wire_o(in_w));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("errors=%0d compared=%0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // classic single cycle; waits for ack (only the watchdog ends a hang), then idles one cycle
  task automatic wb(input logic [15:0] a, input logic w, input logic [7:0] d,
                    output logic [7:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] q;
    wb(a, 1'b0, 8'h00, q);
    chk(q, exp);
  endtask

  // pin paths take up to one register plus the two-stage synchroniser
  task automatic settle;
    repeat (5) @(posedge clk_i);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    foreach (map[i]) rd(map[i], rst_val[i]);
    rd(16'hF200, 8'h00);
    // after reset every port-5 pin drives its zero data bit; input-only pin idles high
    rd(pin_status_addr, 8'h02);
    // lane 0 off: the write must be dropped
    sel <= 4'h0;
    wr(port5_output_data_addr, 8'h0F);
    sel <= 4'h1;
    rd(port5_output_data_addr, 8'h00);
  endtask

  // tx only in serial function, rx left on the input-only pin
  task automatic t_tx_route;
    wr(port5_function_sel_low_addr, 8'h08);
    wr(port5_function_sel_high_addr, 8'h00);
    wr(port5_drive_ctrl_low_addr, 8'h08);
    wr(port5_drive_ctrl_high_addr, 8'h08);
    wr(port5_direction_addr, 8'h04);
    rd(port5_function_sel_low_addr, 8'h08);
    for (int d = 0; d < 2; d++) begin
      for (int t = 0; t < 2; t++) begin
        wr(port5_output_data_addr, d[0] ? 8'h0C : 8'h00);
        tx_line <= t[0];
        in_lvl  <= ~t[0];
        settle();
        chk({6'h00, tx_oe, tx_w}, {6'h00, 1'b1, t[0]});
        chk({7'h00, rx_o}, {7'h00, ~t[0]});
        chk({7'h00, alt_o}, {7'h00, d[0]});
      end
    end
  endtask

  // both pins serial; the select bit alone picks the rx source
  task automatic t_rx_select;
    wr(port5_function_sel_low_addr, 8'h0C);
    for (int m = 0; m < 2; m++) begin
      wr(chan1_mode_reg0_addr, m[0] ? 8'h10 : 8'h00);
      for (int v = 0; v < 2; v++) begin
        in_lvl  <= v[0];
        alt_lvl <= ~v[0];
        settle();
        chk({7'h00, rx_o}, {7'h00, v[0] ^ m[0]});
        chk({7'h00, alt_oe}, 8'h00);
        chk({7'h00, alt_o}, 8'h00);
      end
    end
    rd(chan1_mode_reg0_addr, 8'h10);
  endtask

  // every drive code on both rx pins, tx drive bits kept at push-pull
  task automatic t_pull_modes;
    for (int c = 0; c < 4; c++) begin
      wr(port5_drive_ctrl_high_addr, {4'h0, 1'b1, c[1], 2'b00});
      wr(port5_drive_ctrl_low_addr, {4'h0, 1'b1, c[0], 2'b00});
      wr(port0_drive_ctrl_high_addr, {4'h0, c[0], 3'b000});
      wr(port0_drive_ctrl_low_addr, {4'h0, c[1], 3'b000});
      settle();
      chk({6'h00, alt_pm}, {6'h00, c[1], c[0]});
      chk({6'h00, in_pm}, {6'h00, c[0], c[1]});
      chk({7'h00, tx_oe}, 8'h01);
    end
  endtask

  // clock enable low freezes the pins; they catch up once it is back
  task automatic t_freeze;
    ce      <= 1'b0;
    tx_line <= 1'b0;
    settle();
    chk({7'h00, tx_w}, 8'h01);
    ce <= 1'b1;
    settle();
    chk({7'h00, tx_w}, 8'h00);
  endtask

  // tx pin out of serial function falls back to its data bit, both levels
  task automatic t_tx_plain;
    wr(port5_function_sel_low_addr, 8'h04);
    for (int b = 0; b < 2; b++) begin
      wr(port5_output_data_addr, b[0] ? 8'h08 : 8'h00);
      tx_line <= ~b[0];
      settle();
      chk({6'h00, tx_oe, tx_w}, {6'h00, 1'b1, b[0]});
    end
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_tx_route();
    t_rx_select();
    t_pull_modes();
    t_freeze();
    t_tx_plain();
    stop_test();
  end

  // the run needs well under 1000 cycles
  initial begin
    #(50 * 4000);
    error_cnt++;
    stop_test();
  end
endmodule // uart1_pin_routing_tb

// ---- verilog/in_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module in_sync
  import pin_routing_pkg::*;
#(
  parameter int width = 2
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic [width-1:0] async_i,
  output logic      [width-1:0] sync_o
);
  typedef struct packed {
    logic [width-1:0] first;
    logic [width-1:0] second;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  // only the second stage is visible outside
  always_comb begin
    next_state        = state;
    next_state.first  = async_i;
    next_state.second = state.first;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= '0;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  assign sync_o = state.second;
endmodule // in_sync

// ---- verilog/uart1_pin_routing.sv ----
// pin routing of the second serial channel: tx on port-5 bit 3, rx mux
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
module uart1_pin_routing
  import pin_routing_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [15:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // serial channel side
  input  wire logic        chan1_transmit_line_i,
  output logic             chan1_receive_line_o,
  // pins
  input  wire logic        serial_tx_port_pin_i,
  output logic             serial_tx_port_pin_o,
  output logic             serial_tx_port_pin_oe_o,
  input  wire logic        serial_rx_alt_port_pin_i,
  output logic             serial_rx_alt_port_pin_o,
  output logic             serial_rx_alt_port_pin_oe_o,
  input  wire logic        serial_rx_input_only_pin_i,
  output logic [1:0]       rx_alt_pull_mode_o,
  output logic [1:0]       rx_input_pull_mode_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  port0_output_data;
    logic [7:0]  port0_drive_ctrl_low;
    logic [7:0]  port0_drive_ctrl_high;
    logic [7:0]  port5_output_data;
    logic [7:0]  port5_direction;
    logic [7:0]  port5_drive_ctrl_low;
    logic [7:0]  port5_drive_ctrl_high;
    logic [7:0]  port5_function_sel_low;
    logic [7:0]  port5_function_sel_high;
    logic [7:0]  chan1_mode_reg0;
    logic [31:0] rdata;
    logic        tx_out;
    logic        tx_oe;
    logic        alt_out;
    logic        alt_oe;
    logic        rx_line;
    logic [1:0]  alt_pull;
    logic [1:0]  in_pull;
  } route_state_t;

  route_state_t state;
  route_state_t next_state;

  logic       wr;
  logic       ack;
  logic [1:0] pins_sync;
  logic       tx_pin_sync;
  logic       tx_serial;
  logic       alt_serial;
  logic       tx_push_pull;
  logic       rx_sel;
  logic [7:0] pin_status;

  // ------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------
  wb_slave u_bus (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .cyc_i  (cyc_i),
    .stb_i  (stb_i),
    .we_i   (we_i),
    .sel0_i (sel_i[0]),
    .wr_o   (wr),
    .ack_o  (ack)
  );

  // pin inputs cross into the clock domain before use
  in_sync #(.width(3)) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .async_i ({serial_tx_port_pin_i, serial_rx_alt_port_pin_i,
               serial_rx_input_only_pin_i}),
    .sync_o  ({tx_pin_sync, pins_sync})
  );

  // ------------------------------------------------------------
  // routing decode
  // ------------------------------------------------------------
  // secondary function = high select 0, low select 1
  assign tx_serial  = {state.port5_function_sel_high[tx_bit],
                       state.port5_function_sel_low[tx_bit]} == func_secondary;
  assign alt_serial = {state.port5_function_sel_high[rx_alt_bit],
                       state.port5_function_sel_low[rx_alt_bit]} == func_secondary;
  assign tx_push_pull = {state.port5_drive_ctrl_high[tx_bit],
                         state.port5_drive_ctrl_low[tx_bit]} == drive_push_pull;
  assign rx_sel = state.chan1_mode_reg0[rx_sel_bit];
  assign pin_status = {4'h0, tx_pin_sync, pins_sync[1], pins_sync[0], rx_sel};

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // register writes, read mux and registered pin drive
  always_comb begin
    next_state = state;
    if (wr) begin
      case (adr_i)
        port0_output_data_addr:       next_state.port0_output_data = dat_i[7:0];
        port0_drive_ctrl_low_addr:    next_state.port0_drive_ctrl_low = dat_i[7:0];
        port0_drive_ctrl_high_addr:   next_state.port0_drive_ctrl_high = dat_i[7:0];
        port5_output_data_addr:       next_state.port5_output_data = dat_i[7:0];
        port5_direction_addr:         next_state.port5_direction = dat_i[7:0];
        port5_drive_ctrl_low_addr:    next_state.port5_drive_ctrl_low = dat_i[7:0];
        port5_drive_ctrl_high_addr:   next_state.port5_drive_ctrl_high = dat_i[7:0];
        port5_function_sel_low_addr:  next_state.port5_function_sel_low = dat_i[7:0];
        port5_function_sel_high_addr: next_state.port5_function_sel_high = dat_i[7:0];
        chan1_mode_reg0_addr:         next_state.chan1_mode_reg0 = dat_i[7:0];
        default: ;
      endcase
    end
    // read data prepared while the ack is pending; unmapped reads zero
    case (adr_i)
      port0_output_data_addr:       next_state.rdata = {24'h0, state.port0_output_data};
      port0_drive_ctrl_low_addr:    next_state.rdata = {24'h0, state.port0_drive_ctrl_low};
      port0_drive_ctrl_high_addr:   next_state.rdata = {24'h0, state.port0_drive_ctrl_high};
      port5_output_data_addr:       next_state.rdata = {24'h0, state.port5_output_data};
      port5_direction_addr:         next_state.rdata = {24'h0, state.port5_direction};
      port5_drive_ctrl_low_addr:    next_state.rdata = {24'h0, state.port5_drive_ctrl_low};
      port5_drive_ctrl_high_addr:   next_state.rdata = {24'h0, state.port5_drive_ctrl_high};
      port5_function_sel_low_addr:  next_state.rdata = {24'h0, state.port5_function_sel_low};
      port5_function_sel_high_addr: next_state.rdata = {24'h0, state.port5_function_sel_high};
      chan1_mode_reg0_addr:         next_state.rdata = {24'h0, state.chan1_mode_reg0};
      pin_status_addr:              next_state.rdata = {24'h0, pin_status};
      default:                      next_state.rdata = 32'h0;
    endcase

    // tx pin: serial line replaces data bit while in secondary function
    next_state.tx_out = tx_serial ? chan1_transmit_line_i
                                  : state.port5_output_data[tx_bit];
    next_state.tx_oe  = ~state.port5_direction[tx_bit] & (tx_serial ? tx_push_pull : 1'b1);

    // alt rx pin: dir 1 makes it an input; its data bit never reaches it in serial mode
    next_state.alt_oe  = ~state.port5_direction[rx_alt_bit];
    next_state.alt_out = alt_serial ? 1'b0 : state.port5_output_data[rx_alt_bit];

    // pull modes follow software choice unchanged
    next_state.alt_pull = {state.port5_drive_ctrl_high[rx_alt_bit],
                           state.port5_drive_ctrl_low[rx_alt_bit]};
    next_state.in_pull  = {state.port0_drive_ctrl_high[rx_input_bit],
                           state.port0_drive_ctrl_low[rx_input_bit]};

    // rx source: select 0 always the input-only pin, no direction needed
    if (!rx_sel) begin
      next_state.rx_line = pins_sync[0];
    end else begin
      next_state.rx_line = (alt_serial & state.port5_direction[rx_alt_bit]) ? pins_sync[1]
                                                                            : 1'b1;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state                         <= '0;
      state.port0_output_data       <= data_reset;
      state.port5_output_data       <= data_reset;
      state.port5_direction         <= dir_reset;
      state.port0_drive_ctrl_low    <= drive_reset;
      state.port0_drive_ctrl_high   <= drive_reset;
      state.port5_drive_ctrl_low    <= drive_reset;
      state.port5_drive_ctrl_high   <= drive_reset;
      state.port5_function_sel_low  <= func_reset;
      state.port5_function_sel_high <= func_reset;
      state.chan1_mode_reg0         <= mode_reset;
      state.rx_line                 <= 1'b1;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  assign dat_o                       = state.rdata;
  assign ack_o                       = ack;
  assign chan1_receive_line_o        = state.rx_line;
  assign serial_tx_port_pin_o        = state.tx_out;
  assign serial_tx_port_pin_oe_o     = state.tx_oe;
  assign serial_rx_alt_port_pin_o    = state.alt_out;
  assign serial_rx_alt_port_pin_oe_o = state.alt_oe;
  assign rx_alt_pull_mode_o          = state.alt_pull;
  assign rx_input_pull_mode_o        = state.in_pull;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // serial line reaches the tx pin one register later
  chk_tx_follows_line: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && tx_serial |=> serial_tx_port_pin_o == $past(chan1_transmit_line_i))
    else $error("tx pin does not follow serial line");

  // push-pull code with dir 0 drives the tx pin
  chk_tx_push_pull: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && tx_serial && tx_push_pull && !state.port5_direction[tx_bit]
      |=> serial_tx_port_pin_oe_o)
    else $error("tx pin not driven in push-pull mode");

  // any other drive code in serial mode leaves the pin released
  chk_tx_released: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && tx_serial && !tx_push_pull |=> !serial_tx_port_pin_oe_o)
    else $error("tx pin driven without push-pull code");

  // select 0 keeps the input-only pin whatever the alternate pin holds
  chk_rx_input_only: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !rx_sel |=> chan1_receive_line_o == $past(pins_sync[0]))
    else $error("rx not taken from input-only pin");

  // select 1 takes the alternate pin once it is a serial input
  chk_rx_alt_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && rx_sel && alt_serial && state.port5_direction[rx_alt_bit]
      |=> chan1_receive_line_o == $past(pins_sync[1]))
    else $error("rx not taken from alternate pin");

  // dir 1 keeps the alternate pin off the wire
  chk_alt_is_input: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && state.port5_direction[rx_alt_bit] |=> !serial_rx_alt_port_pin_oe_o)
    else $error("alternate rx pin driven while input");

  // dir 0 turns the alternate pin into an output
  chk_alt_drives: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !state.port5_direction[rx_alt_bit] |=> serial_rx_alt_port_pin_oe_o)
    else $error("alternate pin not driven with dir 0");

  // a data bit change in serial mode must not show on the tx pin
  chk_data_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && tx_serial && $changed(state.port5_output_data[tx_bit])
      |=> serial_tx_port_pin_o == $past(chan1_transmit_line_i))
    else $error("data bit reached serial tx pin");

  // alternate pin in serial mode never shows its data bit
  chk_alt_data_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && alt_serial |=> !serial_rx_alt_port_pin_o)
    else $error("data bit reached alternate serial pin");

  // raw select bits, not the shared decode, so a broken decode shows up
  chk_func_decode: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !(!state.port5_function_sel_high[tx_bit]
              && state.port5_function_sel_low[tx_bit])
      |=> serial_tx_port_pin_o == $past(state.port5_output_data[tx_bit]))
    else $error("tx pin left its data bit outside serial function");

  // pull modes pass straight from the drive bits
  chk_alt_pull_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> rx_alt_pull_mode_o == $past({state.port5_drive_ctrl_high[rx_alt_bit],
                                          state.port5_drive_ctrl_low[rx_alt_bit]}))
    else $error("alternate pin pull mode lost");

  chk_in_pull_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> rx_input_pull_mode_o == $past({state.port0_drive_ctrl_high[rx_input_bit],
                                            state.port0_drive_ctrl_low[rx_input_bit]}))
    else $error("input-only pin pull mode lost");

  // enable low must freeze every register, bus front end included
  chk_ce_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(state) && $stable(ack_o))
    else $error("state moved while clock enable low");

  // single-cycle handshake: ack never stands two cycles while ce_i is high
  chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o && ce_i |=> !ack_o)
    else $error("ack held over two cycles");

  // registers are one byte wide, upper lanes always read zero
  chk_read_upper: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |-> dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
endmodule // uart1_pin_routing

// ---- verilog/wb_slave.sv ----
// classic wishbone slave front end, one cycle ack
`timescale 1ns/1ps
module wb_slave
  import pin_routing_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic        sel0_i,
  output logic             wr_o,
  output logic             ack_o
);
  typedef struct packed {
    logic ack;
  } wb_state_t;

  wb_state_t state;
  wb_state_t next_state;

  // ack one cycle after request, dropped the cycle after
  always_comb begin
    next_state     = state;
    next_state.ack = cyc_i & stb_i & ~state.ack;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= '0;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // write commits at the ack edge, only with lane 0 enabled
  assign wr_o  = state.ack & cyc_i & stb_i & we_i & sel0_i;
  assign ack_o = state.ack;
endmodule // wb_slave
